// file: rtl/accum_rotate_pkg.sv
// Constants and types for the extended accumulator and rotate unit
package accum_rotate_pkg;
  localparam int ExtWidth = 8;
  localparam logic [5:0] OpcSpecial = 6'h00;
  localparam logic [5:0] OpcGroupB = 6'h1c;
  localparam logic [5:0] FnRotImm = 6'h02;
  localparam logic [5:0] FnRotVar = 6'h06;
  localparam logic [5:0] FnFeed = 6'h13;
  localparam logic [5:0] FnMult = 6'h19;
  localparam logic [5:0] FnMaddGrp = 6'h01;
  localparam logic [4:0] SubFeed = 5'h01;
  localparam logic [4:0] SubPoly = 5'h11;
  localparam logic [4:0] SubUnsigned = 5'h00;
  localparam logic [4:0] SubMadd = 5'h00;
  localparam logic [4:0] SubPerm = 5'h12;
  localparam int PermShift = 6;
  localparam logic [31:0] WordReset = 32'h0000_0000;
  typedef enum logic [3:0] {
    OP_NONE, OP_MULTIPLY_ADD_UNSIGNED, OP_DRAIN, OP_FEED, OP_POLY, OP_MULU, OP_PERM, OP_ROTI, OP_ROTV, OP_RESV
  } op_e;
endpackage : accum_rotate_pkg

// file: rtl/extended_accumulator_rotate_unit.sv
// Extended accumulator, multiply, permute and rotate execution unit
`timescale 1ns/100ps
`default_nettype none
module extended_accumulator_rotate_unit (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic issueValid, // Instruction issued this cycle
  input wire logic [31:0] instrWord, // Decoded instruction word
  input wire logic [31:0] sourceA, // Value of source_a_index register
  input wire logic [31:0] sourceB, // Value of source_b_index register
  input wire logic wideEnable, // 64-bit operation available and enabled
  input wire logic archRev2, // Architecture revision two or later
  input wire logic ext_present_flag, // Extension present
  input wire logic drainIsMove, // Issued word is the drain instruction
  output logic resultValid, // Register result valid
  output logic [31:0] resultData, // Result for target register
  output logic reservedTrap, // Reserved-instruction exception pulse
  output logic [accum_rotate_pkg::ExtWidth-1:0] carry_extension_bits, // Extension bits
  output logic [31:0] upper_product_word, // Upper product word
  output logic [31:0] bottom_product_word // Bottom product word
);
  // Extension width and the part that narrow moves carry
  localparam int ExtW = accum_rotate_pkg::ExtWidth;
  localparam int ExtCut = (ExtW < 32) ? ExtW : 32;

  logic rstMeta;
  logic rstSync;
  accum_rotate_pkg::op_e op;
  logic [63:0] product;
  logic [63:0] polyProduct;
  logic [ExtW+63:0] maddSum;
  logic [5:0] permBits;
  logic [31:0] rotImm;
  logic [31:0] rotVar;
  logic [31:0] drainHi;
  logic [ExtW-1:0] feedExt;
  logic [5:0] opcode;
  logic [5:0] func;
  logic [4:0] sub;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Instruction fields
  assign opcode = instrWord[31:26];
  assign func = instrWord[5:0];
  assign sub = instrWord[10:6];

  // Instruction decode
  always_comb begin
    op = accum_rotate_pkg::OP_NONE;
    if (opcode == accum_rotate_pkg::OpcSpecial) begin
      if (func == accum_rotate_pkg::FnRotImm && instrWord[21] && instrWord[25:22] == 4'h0) begin
        op = (archRev2 || ext_present_flag) ? accum_rotate_pkg::OP_ROTI
                                            : accum_rotate_pkg::OP_RESV;
      end else if (func == accum_rotate_pkg::FnRotVar && instrWord[6]
                   && instrWord[10:7] == 4'h0) begin
        op = (archRev2 || ext_present_flag) ? accum_rotate_pkg::OP_ROTV
                                            : accum_rotate_pkg::OP_RESV;
      end else if (func == accum_rotate_pkg::FnFeed && sub == accum_rotate_pkg::SubFeed
                   && instrWord[20:11] == 10'h000) begin
        op = accum_rotate_pkg::OP_FEED;
      end else if (func == accum_rotate_pkg::FnMult && sub == accum_rotate_pkg::SubPoly) begin
        op = accum_rotate_pkg::OP_POLY;
      end else if (func == accum_rotate_pkg::FnMult
                   && sub == accum_rotate_pkg::SubUnsigned) begin
        op = accum_rotate_pkg::OP_MULU;
      end else if (drainIsMove) begin
        // Drain has no fixed code here; the pipeline marks it
        op = accum_rotate_pkg::OP_DRAIN;
      end
    end else if (opcode == accum_rotate_pkg::OpcGroupB
                 && func == accum_rotate_pkg::FnMaddGrp) begin
      if (sub == accum_rotate_pkg::SubPerm) begin
        op = accum_rotate_pkg::OP_PERM;
      end else if (sub == accum_rotate_pkg::SubMadd) begin
        op = accum_rotate_pkg::OP_MULTIPLY_ADD_UNSIGNED;
      end
    end
    if (!issueValid) begin
      op = accum_rotate_pkg::OP_NONE;
    end
  end

  // Unsigned product and multiply-accumulate sum
  assign product = 64'(sourceA) * 64'(sourceB);
  assign maddSum = {carry_extension_bits, upper_product_word, bottom_product_word}
                   + (ExtW+64)'(product);

  // Carry-less product, one partial product per bit
  always_comb begin
    polyProduct = 64'h0;
    for (int i = 0; i < 32; i++) begin
      if (sourceB[i]) begin
        polyProduct = polyProduct ^ (64'(sourceA) << i);
      end
    end
  end

  // Six selected bits for the permute
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gSel
      assign permBits[g] = sourceA[sourceB[g*5 +: 5]];
    end
  endgenerate

  // Right rotates
  // A zero amount shifts left by 32, which yields zero
  assign rotImm = (sourceB >> instrWord[10:6])
                  | (sourceB << (6'd32 - {1'b0, instrWord[10:6]}));
  assign rotVar = (sourceB >> sourceA[4:0])
                  | (sourceB << (6'd32 - {1'b0, sourceA[4:0]}));

  // Drain upper word and feed extension, narrowed when wide mode is off
  always_comb begin
    drainHi = 32'h0;
    feedExt = '0;
    drainHi[ExtCut-1:0] = carry_extension_bits[ExtCut-1:0];
    feedExt[ExtCut-1:0] = upper_product_word[ExtCut-1:0];
    if (wideEnable && ExtW > 32) begin
      drainHi = 32'(carry_extension_bits);
      feedExt = ExtW'(upper_product_word);
    end
  end

  // Accumulator state; no operation raises an arithmetic trap
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      carry_extension_bits <= '0;
      upper_product_word <= accum_rotate_pkg::WordReset;
      bottom_product_word <= accum_rotate_pkg::WordReset;
    end else begin
      unique case (op)
        accum_rotate_pkg::OP_MULTIPLY_ADD_UNSIGNED: begin
          carry_extension_bits <= maddSum[ExtW+63:64];
          upper_product_word <= maddSum[63:32];
          bottom_product_word <= maddSum[31:0];
        end
        accum_rotate_pkg::OP_DRAIN: begin
          bottom_product_word <= upper_product_word;
          upper_product_word <= drainHi;
          carry_extension_bits <= '0;
        end
        accum_rotate_pkg::OP_FEED: begin
          carry_extension_bits <= feedExt;
          upper_product_word <= bottom_product_word;
          bottom_product_word <= sourceA;
        end
        accum_rotate_pkg::OP_POLY: begin
          upper_product_word <= polyProduct[63:32];
          bottom_product_word <= polyProduct[31:0];
          carry_extension_bits <= '0;
        end
        accum_rotate_pkg::OP_MULU: begin
          upper_product_word <= product[63:32];
          bottom_product_word <= product[31:0];
          carry_extension_bits <= '0;
        end
        accum_rotate_pkg::OP_PERM: begin
          // Top six extension bits fall off
          {carry_extension_bits, upper_product_word, bottom_product_word} <=
            {carry_extension_bits[ExtW-accum_rotate_pkg::PermShift-1:0], upper_product_word,
             bottom_product_word, permBits};
        end
        default: begin
        end
      endcase
    end
  end

  // Register result and reserved trap
  // Result data holds until the next drain or rotate
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      resultValid <= 1'b0;
      resultData <= 32'h0;
      reservedTrap <= 1'b0;
    end else begin
      resultValid <= (op == accum_rotate_pkg::OP_DRAIN) || (op == accum_rotate_pkg::OP_ROTI)
                     || (op == accum_rotate_pkg::OP_ROTV);
      reservedTrap <= (op == accum_rotate_pkg::OP_RESV);
      unique case (op)
        accum_rotate_pkg::OP_DRAIN: resultData <= bottom_product_word;
        accum_rotate_pkg::OP_ROTI: resultData <= rotImm;
        accum_rotate_pkg::OP_ROTV: resultData <= rotVar;
        default: resultData <= resultData;
      endcase
    end
  end

  // Named steps that the checks below are built from
  sequence drainSeq;
    issueValid && op == accum_rotate_pkg::OP_DRAIN;
  endsequence
  sequence feedSeq;
    op == accum_rotate_pkg::OP_FEED;
  endsequence
  sequence polySeq;
    op == accum_rotate_pkg::OP_POLY;
  endsequence
  sequence permSeq;
    op == accum_rotate_pkg::OP_PERM;
  endsequence
  sequence rotImmSeq;
    op == accum_rotate_pkg::OP_ROTI;
  endsequence
  sequence rotVarSeq;
    op == accum_rotate_pkg::OP_ROTV;
  endsequence
  sequence accOpSeq;
    op == accum_rotate_pkg::OP_MULTIPLY_ADD_UNSIGNED || op == accum_rotate_pkg::OP_DRAIN
      || op == accum_rotate_pkg::OP_FEED || op == accum_rotate_pkg::OP_POLY
      || op == accum_rotate_pkg::OP_MULU || op == accum_rotate_pkg::OP_PERM;
  endsequence
  sequence idleSeq;
    op == accum_rotate_pkg::OP_NONE || op == accum_rotate_pkg::OP_RESV;
  endsequence

  // Drain: word out, words down, extension cleared
  drain_clears_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    drainSeq |=> carry_extension_bits == '0 && resultValid)
    else $error("drain did not clear extension");
  drain_moves_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    drainSeq |=> bottom_product_word == $past(upper_product_word))
    else $error("drain did not move upper word");
  drain_result_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    drainSeq |=> resultData == $past(bottom_product_word))
    else $error("drain result is not the bottom word");
  drain_upper_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    drainSeq |=> upper_product_word[ExtCut-1:0] == $past(carry_extension_bits[ExtCut-1:0])
      && (upper_product_word >> ExtCut) == 32'h0)
    else $error("drain upper word not zero-extended");

  // Feed: words up, extension keeps the low upper bits
  feed_moves_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    feedSeq |=> bottom_product_word == $past(sourceA)
      && upper_product_word == $past(bottom_product_word))
    else $error("feed did not shift words");
  feed_ext_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    feedSeq |=> carry_extension_bits[ExtCut-1:0] == $past(upper_product_word[ExtCut-1:0]))
    else $error("feed extension wrong");

  // Multiplies and multiply-add, summed apart from the datapath
  mulu_product_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    op == accum_rotate_pkg::OP_MULU |=> {upper_product_word, bottom_product_word}
      == $past(sourceA) * $past(sourceB) && carry_extension_bits == '0)
    else $error("unsigned multiply wrong");
  poly_clear_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    polySeq |=> carry_extension_bits == '0)
    else $error("polynomial multiply kept extension");
  poly_bits_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    polySeq |=> bottom_product_word[0] == $past(sourceA[0] & sourceB[0])
      && bottom_product_word[1] == $past(sourceA[0] & sourceB[1] ^ sourceA[1] & sourceB[0])
      && !upper_product_word[31])
    else $error("polynomial product bits wrong");
  madd_carry_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    op == accum_rotate_pkg::OP_MULTIPLY_ADD_UNSIGNED |=> {carry_extension_bits, upper_product_word,
      bottom_product_word} == $past({carry_extension_bits, upper_product_word,
      bottom_product_word}) + $past(sourceA) * $past(sourceB))
    else $error("multiply-add lost carry");

  // Permute: shift by six, six selected bits at the bottom
  perm_shift_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    permSeq |=> upper_product_word
      == {$past(upper_product_word[25:0]), $past(bottom_product_word[31:26])})
    else $error("permute shift wrong");
  perm_select_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    permSeq |=> bottom_product_word[0] == $past(sourceA[sourceB[4:0]])
      && bottom_product_word[5] == $past(sourceA[sourceB[29:25]])
      && bottom_product_word[31:6] == $past(bottom_product_word[25:0]))
    else $error("permute selected wrong bits");

  // Rotates, traps and idle cycles
  rot_imm_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    rotImmSeq |=> resultValid
      && resultData == 32'({$past(sourceB), $past(sourceB)} >> $past(instrWord[10:6])))
    else $error("immediate rotate wrong");
  rot_var_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    op == accum_rotate_pkg::OP_ROTV && sourceA[4:0] == 5'h00 |=> resultData == $past(sourceB))
    else $error("zero rotate changed value");
  rot_var_full_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    rotVarSeq |=> resultValid
      && resultData == 32'({$past(sourceB), $past(sourceB)} >> $past(sourceA[4:0])))
    else $error("variable rotate wrong");
  reserved_trap_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    reservedTrap |-> !resultValid && !$past(archRev2) && !$past(ext_present_flag))
    else $error("reserved trap without cause");
  trap_cause_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    op == accum_rotate_pkg::OP_RESV |=> reservedTrap && !resultValid)
    else $error("reserved rotate did not trap");
  acc_no_trap_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    accOpSeq |=> !reservedTrap)
    else $error("accumulator op raised a trap");
  idle_hold_a: assert property (@(posedge core_clk) disable iff (!rstSync)
    idleSeq |=> $stable(carry_extension_bits) && $stable(upper_product_word)
      && $stable(bottom_product_word) && !resultValid)
    else $error("accumulator changed while idle");
endmodule : extended_accumulator_rotate_unit
`default_nettype wire

// file: tb/accum_pipe_model.sv
// Pipeline issue model that feeds decoded words and operands to the unit
`timescale 1ns/100ps
`default_nettype none
module accum_pipe_model (
  input wire logic core_clk, // Core clock
  output logic issueValid, // Issue strobe
  output logic [31:0] instrWord, // Instruction word
  output logic [31:0] sourceA, // First operand value
  output logic [31:0] sourceB, // Second operand value
  output logic drainIsMove // Drain marker
);
  // Quiet lines at time zero
  initial begin
    issueValid = 1'b0;
    instrWord = 32'h0;
    sourceA = 32'h0;
    sourceB = 32'h0;
    drainIsMove = 1'b0;
  end
  // One word per call; idle cycles show inverted junk so stale values never pass
  task automatic send(input logic v, input logic [31:0] w, a, b, input logic d);
    issueValid <= v;
    instrWord <= v ? w : ~instrWord;
    sourceA <= v ? a : ~sourceA;
    sourceB <= v ? b : ~sourceB;
    drainIsMove <= v & d;
  endtask : send
endmodule : accum_pipe_model
`default_nettype wire

// file: tb/extended_accumulator_rotate_unit_tb_top.sv
// Self-checking bench for the extended accumulator and rotate unit
`timescale 1ns/100ps
`default_nettype none
module extended_accumulator_rotate_unit_tb_top;
  localparam int EW = accum_rotate_pkg::ExtWidth;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wideEnable = 1'b0;
  logic archRev2 = 1'b0;
  logic extFlag = 1'b0;
  wire logic issueValid, drainIsMove, resultValid, reservedTrap;
  wire logic [31:0] instrWord, sourceA, sourceB, resultData, hiWord, loWord;
  wire logic [EW-1:0] extBits;
  logic [EW-1:0] eExt = '0;
  logic [31:0] eHi = '0, eLo = '0, eRes = '0, rnd = 32'h5b2d1383;
  logic eVal = 1'b0, eTrap = 1'b0;
  int n_fail = 0, checks = 0;
  // Free-running core clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  accum_pipe_model i_accum_pipe_model (.core_clk(core_clk), .issueValid(issueValid),
    .instrWord(instrWord), .sourceA(sourceA), .sourceB(sourceB), .drainIsMove(drainIsMove));
  extended_accumulator_rotate_unit i_extended_accumulator_rotate_unit (
    .core_clk(core_clk), .rst_n(rst_n), .issueValid(issueValid), .instrWord(instrWord),
    .sourceA(sourceA), .sourceB(sourceB), .wideEnable(wideEnable), .archRev2(archRev2),
    .ext_present_flag(extFlag), .drainIsMove(drainIsMove), .resultValid(resultValid),
    .resultData(resultData), .reservedTrap(reservedTrap), .carry_extension_bits(extBits),
    .upper_product_word(hiWord), .bottom_product_word(loWord));
  // Random source and reference arithmetic
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  function automatic logic [63:0] polyMul(input logic [31:0] a, b);
    logic [63:0] p;
    p = '0;
    for (int i = 0; i < 32; i++) begin
      if (b[i]) p ^= {32'h0, a} << i;
    end
    return p;
  endfunction : polyMul
  // Mismatch report and compares
  task automatic report(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : report
  task automatic compareAcc();
    checks++;
    if ({extBits, hiWord, loWord} !== {eExt, eHi, eLo}) report("accumulator");
  endtask : compareAcc
  task automatic compareRes();
    checks++;
    if ({resultValid, resultData} !== {eVal, eRes}) report("register result");
  endtask : compareRes
  task automatic compareTrap();
    checks++;
    if (reservedTrap !== eTrap) report("reserved trap");
  endtask : compareTrap
  // Issue one op, check the op taken at this edge, then predict this one
  task automatic step(input int k, input logic [31:0] a, b);
    logic [31:0] w, res;
    logic [EW+63:0] acc;
    logic [4:0] s;
    logic ok;
    s = rnd[16:12];
    ok = rnd[7] | rnd[11];
    acc = {eExt, eHi, eLo};
    res = eRes;
    w = 32'hfc00_003f;
    if (k == 3) b[31:30] = 2'b00;
    case (k)
      0: w = {accum_rotate_pkg::OpcGroupB, 15'h14c0, 11'h001};
      1: w = {accum_rotate_pkg::OpcSpecial, 15'h14c0, accum_rotate_pkg::SubUnsigned, 6'h19};
      2: w = {accum_rotate_pkg::OpcSpecial, 15'h14c0, accum_rotate_pkg::SubPoly, 6'h19};
      3: w = {accum_rotate_pkg::OpcGroupB, 15'h14c0, accum_rotate_pkg::SubPerm, 6'h01};
      4: w = {accum_rotate_pkg::OpcSpecial, 15'h1800, accum_rotate_pkg::SubFeed, 6'h13};
      5: w = {accum_rotate_pkg::OpcSpecial, 15'h0004, 11'h012};
      6: w = {accum_rotate_pkg::OpcSpecial, 15'h04c4, s, accum_rotate_pkg::FnRotImm};
      7: w = {accum_rotate_pkg::OpcSpecial, 15'h14c4, 5'h01, accum_rotate_pkg::FnRotVar};
      default: w = 32'hfc00_003f;
    endcase
    case (k)
      0: acc = acc + (EW+64)'(64'(a) * 64'(b));
      1: acc = (EW+64)'(64'(a) * 64'(b));
      2: acc = (EW+64)'(polyMul(a, b));
      3: acc = {acc[EW+57:0], a[b[29:25]], a[b[24:20]], a[b[19:15]], a[b[14:10]],
                a[b[9:5]], a[b[4:0]]};
      4: acc = {eHi[EW-1:0], eLo, a};
      5: acc = (EW+64)'({eExt, eHi});
      6: res = ok ? 32'({b, b} >> s) : eRes;
      7: res = ok ? 32'({b, b} >> a[4:0]) : eRes;
      default: res = eRes;
    endcase
    if (k == 5) res = eLo;
    @(posedge core_clk);
    i_accum_pipe_model.send(k != 8 || rnd[0], w, a, b, k == 5);
    wideEnable <= rnd[3];
    archRev2 <= rnd[7];
    extFlag <= rnd[11];
    #1;
    compareAcc();
    compareRes();
    compareTrap();
    {eExt, eHi, eLo} = acc;
    eRes = res;
    eVal = k == 5 || ((k == 6 || k == 7) && ok);
    eTrap = (k == 6 || k == 7) && !ok;
  endtask : step
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // Reset, corner ops, then random back-to-back traffic
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    compareAcc();
    compareRes();
    compareTrap();
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 6; i++) step(0, 32'hffff_ffff, 32'hffff_ffff);
    for (int k = 0; k < 9; k++) step(k, 32'hffff_ffff, 32'h3fff_ffff);
    step(7, 32'hffff_ffe0, 32'h3fff_ffff);
    step(5, 32'h0, 32'h0);
    $display("test corner done");
    for (int i = 0; i < 600; i++) begin
      rnd = lfsr(rnd);
      step(int'(rnd[27:24]) % 9, lfsr(rnd), lfsr(lfsr(rnd)));
      rnd = lfsr(lfsr(rnd));
    end
    step(8, 32'h0, 32'h0);
    $display("test random done");
    end_sim();
  end
endmodule : extended_accumulator_rotate_unit_tb_top
`default_nettype wire
